// [hdl/twi_params.svh]
// What this block does
// - Accept only the eight listed command combinations
// - Illegal command word causes no bus action
// - Valid command launches sequence using transmit buffer
// - Master returns selected ACK or NACK after reads
// - Command bit clears pending master interrupt
// - Address and direction wait in transmit buffer
// - Transmit buffer holds one byte until command
// - Received bytes land in readable receive buffer
// - Bus-busy flag covers other masters too
// - Transfer-in-progress flag until own transfer ends
// - Record whether last slave answer was NACK
// - Flag lost arbitration against another master
// - Slave never drives clock, only data
// - Slave own address is 7 or 10 bits
// - Eight-bit mask gates each slave event
// - Mask bits 0-2: request, taken, available
// - Mask bits 3-4: burst end, protocol error
// - Optional filter drops pulses below 62.5 ns
// - Slave flow control always in NACK mode
// - Bus clock is 16/(5*(divider+1)) MHz
`ifndef TWI_PARAMS_SVH
`define TWI_PARAMS_SVH
`define CMD_IDLE 4'h0
`define CMD_START_WRITE 4'h9
`define CMD_START_WRITE_STOP 4'hD
`define CMD_READ_STOP 4'h6
`define CMD_WRITE_STOP 4'h5
`define CMD_WRITE 4'h1
`define CMD_READ 4'h2
`define CMD_STOP 4'h4
`define CLK_MHZ 8'hC8
`define PERIPH_MHZ 8'h10
`define LAST_PHASE 3'h4
`define CLK_PS 5000
`define FILTER_PS 62500
`define FILTER_CYCLES ((`FILTER_PS + `CLK_PS - 1) / `CLK_PS)
`define TEN_BIT_PREFIX 5'h1E
`define EV_DATA_REQUEST 0
`define EV_DATA_TAKEN 1
`define EV_DATA_AVAILABLE 2
`define EV_BURST_END 3
`define EV_PROTOCOL_ERROR 4
`endif

// [hdl/twi_pkg.sv]
package twi_pkg;
	typedef enum {M_IDLE, M_START, M_DATA, M_ACK, M_STOP} master_state_t;
	typedef enum {S_IDLE, S_ADDR, S_ADDR2, S_ADDR_ACK, S_RX, S_RX_ACK, S_TX,
		S_TX_ACK, S_WAIT} slave_state_t;
	typedef logic [3:0] command_t;
	typedef logic [7:0] byte_t;
	typedef logic [4:0] events_t;
endpackage : twi_pkg

// [hdl/glitch_filter.sv]
`timescale 1ns/100ps
`include "twi_params.svh"
module glitch_filter
	import twi_pkg::*;
(
	input wire logic clk,
	input wire logic clk_en,
	input wire logic sys_rst,
	input wire logic filter_on,
	input wire logic line_in,
	output logic line_out
);
	logic [3:0] count;

	// Output follows only after the input differs for the full window
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			line_out <= 1'b1;
			count <= 4'h0;
		end else if (clk_en) begin
			if (!filter_on || line_in == line_out) begin
				line_out <= filter_on ? line_out : line_in;
				count <= 4'h0;
			end else if (count == 4'(`FILTER_CYCLES - 1)) begin
				line_out <= line_in;
				count <= 4'h0;
			end else begin
				count <= count + 4'h1;
			end
		end
	end

	chk_filter_window: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && filter_on && line_in != line_out && count < 4'(`FILTER_CYCLES - 1)
		|=> line_out == $past(line_out))
		else $error("filter passed a short pulse");
endmodule : glitch_filter

// [hdl/twi_slave.sv]
`timescale 1ns/100ps
`include "twi_params.svh"
module twi_slave
	import twi_pkg::*;
(
	input wire logic clk,
	input wire logic clk_en,
	input wire logic sys_rst,
	input wire logic slave_enable,
	input wire logic sda_f,
	input wire logic scl_rise,
	input wire logic scl_fall,
	input wire logic start_seen,
	input wire logic stop_seen,
	input wire logic [9:0] own_address,
	input wire logic ten_bit_address_select,
	input wire logic [7:0] slave_event_enable_mask,
	input wire logic [7:0] slave_tx_data,
	input wire logic slave_tx_load,
	input wire logic slave_rx_take,
	output logic sda_low,
	output byte_t slave_rx_data,
	output events_t slave_events,
	output logic slave_irq,
	output logic slave_busy
);
	slave_state_t state, after_ack;
	byte_t shift, tx_buf;
	logic [3:0] bit_cnt;
	logic rx_full, tx_full, ten_matched;
	events_t ev;

	// Byte engine: sample on rising clock, change data on falling clock
	always_ff @(posedge clk) begin
		if (sys_rst || !slave_enable) begin
			state <= S_IDLE;
			after_ack <= S_IDLE;
			shift <= 8'h00;
			bit_cnt <= 4'h0;
			sda_low <= 1'b0;
			ten_matched <= 1'b0;
			rx_full <= 1'b0;
			slave_rx_data <= 8'h00;
		end else if (clk_en) begin
			if (slave_rx_take)
				rx_full <= 1'b0;
			if (start_seen) begin
				state <= S_ADDR;
				bit_cnt <= 4'h0;
				sda_low <= 1'b0;
			end else if (stop_seen) begin
				state <= S_IDLE;
				sda_low <= 1'b0;
				ten_matched <= 1'b0;
			end else if (scl_rise && state inside {S_ADDR, S_ADDR2, S_RX, S_TX}) begin
				if (state != S_TX)
					shift <= {shift[6:0], sda_f};
				bit_cnt <= bit_cnt + 4'h1;
			end else if (scl_rise && state == S_TX_ACK && sda_f) begin
				after_ack <= S_WAIT; // Master NACK ends the read burst
			end else if (scl_fall) begin
				unique case (state)
					S_ADDR: if (bit_cnt == 4'h8) begin
						if (!ten_bit_address_select && shift[7:1] == own_address[6:0]) begin
							sda_low <= 1'b1;
							after_ack <= shift[0] ? S_TX : S_RX;
							state <= S_ADDR_ACK;
						end else if (ten_bit_address_select && shift[7:3] == `TEN_BIT_PREFIX
							&& shift[2:1] == own_address[9:8]
							&& (!shift[0] || ten_matched)) begin
							sda_low <= 1'b1;
							after_ack <= shift[0] ? S_TX : S_ADDR2;
							state <= S_ADDR_ACK;
						end else begin
							state <= S_WAIT;
						end
					end
					S_ADDR2: if (bit_cnt == 4'h8) begin
						if (shift == own_address[7:0]) begin
							sda_low <= 1'b1;
							ten_matched <= 1'b1;
							after_ack <= S_RX;
							state <= S_ADDR_ACK;
						end else begin
							state <= S_WAIT;
						end
					end
					S_RX: if (bit_cnt == 4'h8) begin
						sda_low <= !rx_full;
						if (!rx_full) begin
							slave_rx_data <= shift;
							rx_full <= 1'b1;
						end
						state <= S_RX_ACK;
					end
					S_TX: if (bit_cnt == 4'h8) begin
						sda_low <= 1'b0;
						after_ack <= S_TX;
						state <= S_TX_ACK;
					end else begin
						sda_low <= !shift[6];
						shift <= {shift[6:0], 1'b0};
					end
					S_ADDR_ACK, S_RX_ACK, S_TX_ACK: begin
						bit_cnt <= 4'h0;
						state <= (state == S_RX_ACK) ? S_RX : after_ack;
						sda_low <= 1'b0;
						if (after_ack == S_TX) begin
							shift <= tx_buf;
							sda_low <= !tx_buf[7];
						end
					end
					S_IDLE, S_WAIT: begin
						sda_low <= 1'b0;
					end
				endcase
			end
		end
	end

	// Transmit buffer: load from the agent, freed when copied into the shift register
	always_ff @(posedge clk) begin
		if (sys_rst || !slave_enable) begin
			tx_buf <= 8'hFF;
			tx_full <= 1'b0;
		end else if (clk_en) begin
			if (slave_tx_load) begin
				tx_buf <= slave_tx_data;
				tx_full <= 1'b1;
			end else if (ev[`EV_DATA_TAKEN]) begin
				tx_full <= 1'b0;
			end
		end
	end

	// Event pulses; a reload from an empty buffer repeats the old byte
	always_comb begin
		ev = 5'h00;
		if (clk_en && slave_enable) begin
			ev[`EV_DATA_TAKEN] = scl_fall && !start_seen && !stop_seen
				&& state inside {S_ADDR_ACK, S_TX_ACK} && after_ack == S_TX;
			ev[`EV_DATA_REQUEST] = ev[`EV_DATA_TAKEN] && !tx_full;
			ev[`EV_DATA_AVAILABLE] = scl_fall && !start_seen && !stop_seen
				&& state == S_RX && bit_cnt == 4'h8 && !rx_full;
			ev[`EV_BURST_END] = (stop_seen && state inside {S_RX, S_TX_ACK, S_WAIT})
				|| (scl_rise && state == S_TX_ACK && sda_f);
			// A condition at a byte boundary follows one clock rise, so count 1 is clean
			ev[`EV_PROTOCOL_ERROR] = (start_seen || stop_seen) && bit_cnt > 4'h1
				&& bit_cnt != 4'h8 && state inside {S_ADDR, S_ADDR2, S_RX, S_TX};
		end
	end

	// Mask gating; bits 7:5 of the mask have no event behind them
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slave_events <= 5'h00;
			slave_irq <= 1'b0;
			slave_busy <= 1'b0;
		end else if (clk_en) begin
			slave_events <= ev & slave_event_enable_mask[4:0];
			slave_irq <= |(ev & slave_event_enable_mask[4:0]);
			slave_busy <= state != S_IDLE && state != S_WAIT;
		end
	end

	chk_event_masked: assert property (@(posedge clk) disable iff (sys_rst)
		(slave_events & ~slave_event_enable_mask[4:0]) == 5'h00 || !$past(clk_en))
		else $error("unmasked slave event reported");
endmodule : twi_slave

// [hdl/two_wire_master_slave_port.sv]
`timescale 1ns/100ps
`include "twi_params.svh"
module two_wire_master_slave_port
	import twi_pkg::*;
(
	input wire logic clk,
	input wire logic clk_en,
	input wire logic sys_rst,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic glitch_filter_on,
	input wire logic master_enable,
	input wire logic [7:0] bus_clock_divider,
	input wire logic [6:0] target_address,
	input wire logic direction_is_read,
	input wire logic address_load,
	input wire logic [7:0] tx_data,
	input wire logic data_load,
	input wire logic begin_condition_request,
	input wire logic end_condition_request,
	input wire logic slave_read_request,
	input wire logic slave_write_request,
	input wire logic acknowledge_select,
	input wire logic interrupt_clear_request,
	input wire logic command_strobe,
	output byte_t rx_data,
	output logic bus_busy,
	output logic transfer_in_progress,
	output logic nack_received,
	output logic arbitration_lost,
	output logic command_refused,
	output logic master_irq,
	input wire logic slave_enable,
	input wire logic [9:0] own_address,
	input wire logic ten_bit_address_select,
	input wire logic [7:0] slave_event_enable_mask,
	input wire logic flow_control_select,
	output logic flow_control_invalid,
	input wire logic [7:0] slave_tx_data,
	input wire logic slave_tx_load,
	input wire logic slave_rx_take,
	output byte_t slave_rx_data,
	output events_t slave_events,
	output logic slave_irq,
	output logic slave_busy
);
	logic scl_s1, scl_s2, sda_s1, sda_s2;
	logic scl_f, sda_f, scl_prev, sda_prev;
	logic start_seen, stop_seen, scl_rise, scl_fall;
	logic slave_sda_low;
	master_state_t state;
	command_t cmd, run_cmd;
	logic cmd_ok, accept, done_pulse, arb_hit, phase_tick, tick16;
	logic [2:0] phase;
	logic [2:0] bit_cnt;
	logic [7:0] acc, div_cnt;
	byte_t tx_buf, shift;
	logic scl_low, sda_low, send_nack;

	////////////////////////////////////////////////////////////////////////
	// Pin capture, filtering and condition detection

	// Two-stage synchronisers; only the second stage is read further on
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
		end else if (clk_en) begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
		end
	end

	glitch_filter scl_filter (
		.clk(clk),
		.clk_en(clk_en),
		.sys_rst(sys_rst),
		.filter_on(glitch_filter_on),
		.line_in(scl_s2),
		.line_out(scl_f)
	);

	glitch_filter sda_filter (
		.clk(clk),
		.clk_en(clk_en),
		.sys_rst(sys_rst),
		.filter_on(glitch_filter_on),
		.line_in(sda_s2),
		.line_out(sda_f)
	);

	// Previous filtered levels for edge and condition detection
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else if (clk_en) begin
			scl_prev <= scl_f;
			sda_prev <= sda_f;
		end
	end

	assign start_seen = scl_f && scl_prev && sda_prev && !sda_f;
	assign stop_seen = scl_f && scl_prev && !sda_prev && sda_f;
	assign scl_rise = scl_f && !scl_prev;
	assign scl_fall = !scl_f && scl_prev;

	// Busy follows wire conditions; an own launch sets it at once, and tying it to
	// the engine state would keep it up past our own stop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_busy <= 1'b0;
		end else if (clk_en) begin
			if (start_seen || (accept && cmd != `CMD_IDLE))
				bus_busy <= 1'b1;
			else if (stop_seen)
				bus_busy <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master bus clock timebase

	// Fractional accumulator makes an exact average 16 MHz tick from 200 MHz
	always_ff @(posedge clk) begin
		if (sys_rst || (clk_en && state == M_IDLE)) begin
			acc <= 8'h00;
			div_cnt <= 8'h00;
		end else if (clk_en) begin
			acc <= tick16 ? acc + `PERIPH_MHZ - `CLK_MHZ : acc + `PERIPH_MHZ;
			if (tick16)
				div_cnt <= (div_cnt == bus_clock_divider) ? 8'h00 : div_cnt + 8'h01;
		end
	end

	assign tick16 = acc >= `CLK_MHZ - `PERIPH_MHZ;
	// Five phases of (divider+1) ticks make one bus clock period
	assign phase_tick = tick16 && div_cnt == bus_clock_divider;

	////////////////////////////////////////////////////////////////////////
	// Command decode and buffers

	assign cmd = {begin_condition_request, end_condition_request,
		slave_read_request, slave_write_request};

	// Only the eight listed words pass; start+stop only together with write, read+write never
	always_comb begin
		unique case (cmd)
			`CMD_IDLE, `CMD_START_WRITE, `CMD_START_WRITE_STOP, `CMD_READ_STOP,
			`CMD_WRITE_STOP, `CMD_WRITE, `CMD_READ, `CMD_STOP: cmd_ok = 1'b1;
			default: cmd_ok = 1'b0;
		endcase
	end

	// A command is taken only while the engine is idle
	assign accept = command_strobe && cmd_ok && state == M_IDLE && master_enable;
	assign arb_hit = state == M_DATA && phase == 3'h3 && phase_tick
		&& !run_cmd[1] && !sda_low && !sda_f;

	// Agent loads either an address byte (prefix byte for 10-bit) or data
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_buf <= 8'h00;
		end else if (clk_en) begin
			if (address_load)
				tx_buf <= {target_address, direction_is_read};
			else if (data_load)
				tx_buf <= tx_data;
		end
	end

	// Pulse for any refused word: illegal, issued while busy, or issued with the master disabled
	always_ff @(posedge clk) begin
		if (sys_rst)
			command_refused <= 1'b0;
		else if (clk_en)
			command_refused <= command_strobe && !accept;
	end

	////////////////////////////////////////////////////////////////////////
	// Master sequencer: each step is five phases

	always_ff @(posedge clk) begin
		if (sys_rst || !master_enable) begin
			state <= M_IDLE;
			run_cmd <= `CMD_IDLE;
			phase <= 3'h0;
			bit_cnt <= 3'h0;
			shift <= 8'h00;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			send_nack <= 1'b0;
			done_pulse <= 1'b0;
		end else if (clk_en) begin
			done_pulse <= 1'b0;
			if (state == M_IDLE) begin
				if (accept && cmd != `CMD_IDLE) begin
					run_cmd <= cmd;
					send_nack <= acknowledge_select;
					shift <= tx_buf;
					phase <= 3'h0;
					bit_cnt <= 3'h0;
					state <= cmd[3] ? M_START : (cmd[1] || cmd[0]) ? M_DATA : M_STOP;
				end
			end else if (arb_hit) begin
				// Back off at once so the winner keeps a clean bus
				state <= M_IDLE;
				scl_low <= 1'b0;
				sda_low <= 1'b0;
				done_pulse <= 1'b1;
			end else if (phase_tick) begin
				phase <= (phase == `LAST_PHASE) ? 3'h0 : phase + 3'h1;
				unique case (state)
					M_START: begin
						if (phase == 3'h0)
							sda_low <= 1'b0;
						if (phase == 3'h1)
							scl_low <= 1'b0;
						if (phase == 3'h3)
							sda_low <= 1'b1;
						if (phase == `LAST_PHASE) begin
							scl_low <= 1'b1;
							state <= M_DATA;
						end
					end
					M_DATA: begin
						if (phase == 3'h0)
							sda_low <= !run_cmd[1] && !shift[7];
						if (phase == 3'h2)
							scl_low <= 1'b0;
						if (phase == 3'h3)
							shift <= {shift[6:0], sda_f};
						if (phase == `LAST_PHASE) begin
							scl_low <= 1'b1;
							bit_cnt <= bit_cnt + 3'h1;
							if (bit_cnt == 3'h7)
								state <= M_ACK;
						end
					end
					M_ACK: begin
						if (phase == 3'h0)
							sda_low <= run_cmd[1] && !send_nack;
						if (phase == 3'h2)
							scl_low <= 1'b0;
						if (phase == `LAST_PHASE) begin
							scl_low <= 1'b1;
							sda_low <= 1'b0;
							state <= run_cmd[2] ? M_STOP : M_IDLE;
							done_pulse <= !run_cmd[2];
						end
					end
					M_STOP: begin
						if (phase == 3'h0)
							sda_low <= 1'b1;
						if (phase == 3'h1)
							scl_low <= 1'b0;
						if (phase == 3'h3)
							sda_low <= 1'b0;
						if (phase == `LAST_PHASE) begin
							state <= M_IDLE;
							done_pulse <= 1'b1;
						end
					end
					M_IDLE: begin
						state <= M_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master status

	// Receive byte, last answer and arbitration record
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_data <= 8'h00;
			nack_received <= 1'b0;
			arbitration_lost <= 1'b0;
		end else if (clk_en) begin
			if (state == M_ACK && phase == 3'h3 && phase_tick) begin
				if (run_cmd[1])
					rx_data <= shift;
				else
					nack_received <= sda_f;
			end
			if (arb_hit)
				arbitration_lost <= 1'b1;
			else if (accept && cmd != `CMD_IDLE)
				arbitration_lost <= 1'b0;
		end
	end

	// Interrupt: completion sets it and wins over a same-cycle clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			master_irq <= 1'b0;
			transfer_in_progress <= 1'b0;
		end else if (clk_en) begin
			if (done_pulse)
				master_irq <= 1'b1;
			else if (accept && interrupt_clear_request)
				master_irq <= 1'b0;
			transfer_in_progress <= (state != M_IDLE && !arb_hit)
				|| (accept && cmd != `CMD_IDLE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Slave and pin drive

	twi_slave slave_port (
		.clk(clk),
		.clk_en(clk_en),
		.sys_rst(sys_rst),
		.slave_enable(slave_enable),
		.sda_f(sda_f),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_seen(start_seen),
		.stop_seen(stop_seen),
		.own_address(own_address),
		.ten_bit_address_select(ten_bit_address_select),
		.slave_event_enable_mask(slave_event_enable_mask),
		.slave_tx_data(slave_tx_data),
		.slave_tx_load(slave_tx_load),
		.slave_rx_take(slave_rx_take),
		.sda_low(slave_sda_low),
		.slave_rx_data(slave_rx_data),
		.slave_events(slave_events),
		.slave_irq(slave_irq),
		.slave_busy(slave_busy)
	);

	// Open-drain: only the enables move; the slave never touches the clock
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			flow_control_invalid <= 1'b0;
		end else if (clk_en) begin
			scl_oe <= scl_low;
			sda_oe <= sda_low || slave_sda_low;
			flow_control_invalid <= flow_control_select;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence launch_seq;
		clk_en && accept && cmd != `CMD_IDLE;
	endsequence

	sequence refuse_seq;
		clk_en && command_strobe && !cmd_ok && state == M_IDLE;
	endsequence

	chk_refuse_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		refuse_seq |=> state == M_IDLE && command_refused)
		else $error("illegal command started the bus");

	chk_cmd_launch: assert property (@(posedge clk) disable iff (sys_rst)
		launch_seq |=> transfer_in_progress && state != M_IDLE && shift == $past(tx_buf))
		else $error("valid command did not launch");

	chk_irq_clear: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && accept && interrupt_clear_request && !done_pulse |=> !master_irq)
		else $error("interrupt acknowledge ignored");

	chk_ack_drive: assert property (@(posedge clk) disable iff (sys_rst)
		state == M_ACK && run_cmd[1] && phase inside {3'h1, 3'h2, 3'h3}
		|-> sda_low == !send_nack)
		else $error("wrong acknowledge after read");

	chk_rx_capture: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && state == M_ACK && run_cmd[1] && phase == 3'h3 && phase_tick
		|=> rx_data == $past(shift))
		else $error("received byte not stored");

	chk_busy_start: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && start_seen |=> bus_busy)
		else $error("start seen but bus not busy");

	chk_tip_done: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && done_pulse |=> !transfer_in_progress ##1 master_irq || !clk_en)
		else $error("transfer flag outlived transfer");

	chk_arb_flag: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && arb_hit |=> arbitration_lost && !sda_low && !scl_low ##1 !scl_oe)
		else $error("arbitration loss not handled");

	chk_slave_scl: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && state == M_IDLE && !scl_low |=> !scl_oe)
		else $error("clock driven outside master operation");
endmodule : two_wire_master_slave_port

// [tb/twi_bus_slave_model.sv]
`timescale 1ns/100ps
module twi_bus_slave_model #(
	parameter logic [6:0] ADDR = 7'h50
) (
	input wire logic scl,
	input wire logic sda,
	output logic sda_low
);
	logic [7:0] sh;
	logic [7:0] rom [2] = '{8'hC3, 8'h96};
	logic [7:0] log_b [2];
	int cnt = 9;
	int ti = 0;
	int wi = 0;
	logic first = 0;
	logic sel = 0;
	logic rd = 0;
	logic nak = 1;
	initial sda_low = 0;
	// Framing: a start rearms the byte count, a stop drops the selection
	always @(sda) begin
		if (scl === 1 && !sda)
			{cnt, first} = {32'sd0, 1'b1};
		if (scl === 1 && sda)
			sel = 0;
	end
	// Sample on the rising clock; the ninth bit is the master's answer
	always @(posedge scl) begin
		if (cnt < 8)
			sh = {sh[6:0], sda};
		if (cnt == 8)
			nak = sda;
		cnt = cnt + 1;
	end
	// Drive only while the clock is low, so no false start or stop is made
	always @(negedge scl) begin
		if (cnt == 8 && first)
			{sel, rd, ti} = {sh[7:1] == ADDR, sh[0], 32'sd0};
		if (cnt == 8 && sel && !first && !rd) begin
			log_b[wi] = sh;
			wi = wi + 1;
		end
		if (cnt == 8)
			sda_low = sel && (first || !rd);
		else if (cnt == 9) begin
			if (rd && !first)
				ti = ti + 1;
			sda_low = sel && rd && (first || !nak) && !rom[ti][7];
			{cnt, first} = {32'sd0, 1'b0};
		end else if (sel && rd && cnt < 8)
			sda_low = !rom[ti][7 - cnt];
	end
endmodule : twi_bus_slave_model

// [tb/tb_top.sv]
`timescale 1ns/100ps
module tb_top
	import twi_pkg::*;
;
	typedef struct {command_t c; logic [1:0] ld; byte_t b; logic ack; logic q; logic rf;
		logic [1:0] k; byte_t e;} row_t;
	logic clk = 0, sys_rst = 1, clk_en = 1, glitch_filter_on = 1, master_enable = 1;
	logic [7:0] bus_clock_divider = 8'h02, tx_data = 8'h00, slave_tx_data = 8'h00;
	logic [6:0] target_address = 7'h00;
	logic direction_is_read = 0, address_load = 0, data_load = 0, command_strobe = 0;
	logic begin_condition_request = 0, end_condition_request = 0, slave_read_request = 0;
	logic slave_write_request = 0, acknowledge_select = 0, interrupt_clear_request = 0;
	logic slave_enable = 1, ten_bit_address_select = 0, flow_control_select = 0;
	logic [9:0] own_address = 10'h02A;
	logic [7:0] slave_event_enable_mask = 8'h1B;
	logic slave_tx_load = 0, slave_rx_take = 0, hog = 0, p_low, ref_seen = 0;
	logic scl_out, scl_oe, sda_out, sda_oe, bus_busy, transfer_in_progress, nack_received;
	logic arbitration_lost, command_refused, master_irq, flow_control_invalid, slave_irq;
	logic slave_busy;
	byte_t rx_data, slave_rx_data;
	events_t slave_events, ev_seen = 5'h00;
	wire scl = !scl_oe;
	wire sda = !(sda_oe || p_low || hog);
	int error_cnt = 0, compares = 0, n0;
	realtime tq[$];
	row_t rows [16] = '{
		'{4'h3, 0, 0, 0, 0, 1, 3, 0}, '{4'hC, 0, 0, 0, 0, 1, 3, 0},
		'{4'hA, 0, 0, 0, 0, 1, 3, 0}, '{4'h0, 0, 0, 0, 0, 0, 3, 0},
		'{4'h9, 1, 8'hA0, 0, 0, 0, 0, 0}, '{4'h1, 2, 8'hA5, 0, 0, 0, 0, 0},
		'{4'h5, 2, 8'h3C, 0, 0, 0, 0, 0}, '{4'h9, 1, 8'hA1, 0, 0, 0, 0, 0},
		'{4'h2, 0, 0, 0, 0, 0, 1, 8'hC3}, '{4'h6, 0, 0, 1, 0, 0, 1, 8'h96},
		'{4'h9, 1, 8'h66, 0, 0, 0, 0, 1}, '{4'h4, 0, 0, 0, 0, 0, 3, 0},
		'{4'h9, 1, 8'h54, 0, 0, 0, 0, 0}, '{4'h1, 2, 8'h77, 0, 0, 0, 2, 8'h77},
		'{4'h1, 2, 8'h11, 0, 0, 0, 0, 1}, '{4'h4, 0, 0, 0, 0, 0, 3, 0}};
	two_wire_master_slave_port u_two_wire_master_slave_port (.clk, .clk_en, .sys_rst,
		.scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out, .sda_oe, .glitch_filter_on,
		.master_enable, .bus_clock_divider, .target_address, .direction_is_read, .address_load,
		.tx_data, .data_load, .begin_condition_request, .end_condition_request,
		.slave_read_request, .slave_write_request, .acknowledge_select, .interrupt_clear_request,
		.command_strobe, .rx_data, .bus_busy, .transfer_in_progress, .nack_received,
		.arbitration_lost, .command_refused, .master_irq, .slave_enable, .own_address,
		.ten_bit_address_select, .slave_event_enable_mask, .flow_control_select,
		.flow_control_invalid, .slave_tx_data, .slave_tx_load, .slave_rx_take, .slave_rx_data,
		.slave_events, .slave_irq, .slave_busy);
	twi_bus_slave_model #(.ADDR(7'h50)) u_twi_bus_slave_model (.scl(scl), .sda(sda),
		.sda_low(p_low));
	////////////////////////////////////////////////////////////////////////////////
	always #2.5 clk = ~clk;
	// Pulses are one cycle wide, so catch them sticky instead of timing the peek
	always @(posedge clk) begin
		if (command_refused === 1)
			ref_seen <= 1;
		ev_seen <= ev_seen | slave_events;
	end
	always @(posedge scl) tq.push_back($realtime);
	task automatic chk_bit(string n, logic e, logic g);
		compares++;
		if (g !== e)
			{error_cnt, n0} = {error_cnt + 1, n0};
		if (g !== e)
			$display("ERROR %s expected %b seen %b", n, e, g);
	endtask : chk_bit
	task automatic chk_byte(string n, byte_t e, byte_t g);
		compares++;
		if (g !== e)
			error_cnt++;
		if (g !== e)
			$display("ERROR %s expected %h seen %h", n, e, g);
	endtask : chk_byte
	task automatic complete_run();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	// Load the buffer, strobe the word, wait out the transfer under a bound
	task automatic run(row_t r);
		int n;
		@(posedge clk);
		{target_address, direction_is_read, tx_data} <= {r.b, r.b};
		{address_load, data_load} <= {r.ld == 1, r.ld == 2};
		@(posedge clk);
		{address_load, data_load, ref_seen} <= 3'h0;
		{begin_condition_request, end_condition_request, slave_read_request,
			slave_write_request} <= r.c;
		{acknowledge_select, interrupt_clear_request, command_strobe} <= {r.ack, r.q, 1'b1};
		@(posedge clk);
		command_strobe <= 0;
		repeat (3) @(posedge clk);
		chk_bit("refused", r.rf, ref_seen);
		chk_bit("in_progress", !r.rf && r.c != 0, transfer_in_progress);
		chk_bit("bus_busy", !r.rf && r.c != 0, bus_busy);
		for (n = 0; transfer_in_progress !== 0 && n < 9000; n++) @(posedge clk);
		chk_bit("finished", 1, n < 9000);
		repeat (4) @(posedge clk);
		if (r.k == 0) chk_bit("nack", r.e[0], nack_received);
		if (r.k == 1) chk_byte("rx_data", r.e, rx_data);
		if (r.k == 2) chk_byte("slave_rx", r.e, slave_rx_data);
		$display("test command %h done", r.c);
	endtask : run
	task automatic check_rst();
		repeat (20) @(posedge clk);
		chk_byte("reset_flags", 8'h00, {sda_out, flow_control_invalid, transfer_in_progress,
			bus_busy, arbitration_lost, master_irq, sda_oe, scl_oe});
		chk_byte("reset_slave", 8'h00, {slave_irq, slave_busy, scl_out, slave_events});
		chk_byte("reset_rx", 8'h00, rx_data);
	endtask : check_rst
	////////////////////////////////////////////////////////////////////////////////
	// Watchdog: the full run needs about 32000 cycles
	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 0;
		check_rst();
		foreach (rows[i]) run(rows[i]);
		chk_byte("partner_log0", 8'hA5, u_twi_bus_slave_model.log_b[0]);
		chk_byte("partner_log1", 8'h3C, u_twi_bus_slave_model.log_b[1]);
		chk_byte("events", 8'h08, {3'h0, ev_seen});
		chk_bit("irq_set", 1, master_irq);
		run('{4'h0, 0, 0, 0, 1, 0, 3, 0});
		chk_bit("irq_clear", 0, master_irq);
		// Free the slave's receive buffer and give it a byte to send back
		@(posedge clk);
		{slave_rx_take, slave_tx_load, slave_tx_data} <= {2'h3, 8'h5E};
		@(posedge clk);
		{slave_rx_take, slave_tx_load} <= 2'h0;
		run('{4'h9, 1, 8'h55, 0, 0, 0, 0, 0});
		run('{4'h6, 0, 0, 1, 0, 0, 1, 8'h5E});
		// Ten-bit target: prefix byte with the top bits, then the low address byte
		ten_bit_address_select <= 1;
		run('{4'h9, 1, 8'hF0, 0, 0, 0, 0, 0});
		run('{4'h1, 2, 8'h2A, 0, 0, 0, 0, 0});
		run('{4'h5, 2, 8'h3D, 0, 0, 0, 2, 8'h3D});
		// Bit rate: eight clock periods across the nine rising clocks of a bare write byte
		run('{4'h9, 1, 8'hA0, 0, 0, 0, 0, 0});
		n0 = tq.size();
		run('{4'h1, 2, 8'h5A, 0, 0, 0, 0, 0});
		chk_bit("scl_rate", 1, tq[n0 + 8] - tq[n0] > 7400 && tq[n0 + 8] - tq[n0] < 7600);
		// Another party holds data low while the master sends ones
		hog <= 1;
		run('{4'h1, 2, 8'hFF, 0, 0, 0, 3, 0});
		chk_bit("arb_lost", 1, arbitration_lost);
		chk_bit("released", 0, sda_oe || scl_oe);
		hog <= 0;
		repeat (40) @(posedge clk);
		chk_bit("busy_free", 0, bus_busy);
		// A low pulse shorter than the filter window must not pass as a start
		hog <= 1;
		repeat (9) @(posedge clk);
		chk_bit("glitch_start", 0, bus_busy);
		hog <= 0;
		repeat (20) @(posedge clk);
		hog <= 1;
		repeat (40) @(posedge clk);
		chk_bit("busy_other", 1, bus_busy);
		{hog, sys_rst} <= 2'h1;
		repeat (4) @(posedge clk);
		sys_rst <= 0;
		check_rst();
		$display("test reset done");
		complete_run();
	end
endmodule : tb_top
